// ### mul_nop_or_pkg.sv
// Opcodes, timing and decode helpers for the multiply, no-operation and byte OR execute unit
package mul_nop_or_pkg;

  localparam logic [7:0] OPC_NOP         = 8'h00;
  localparam logic [7:0] OPC_MUL         = 8'ha4;
  localparam logic [7:0] OPC_OR_RN       = 8'h48;
  localparam logic [7:0] OPC_OR_RN_MASK  = 8'hf8;
  localparam logic [7:0] OPC_OR_IND      = 8'h46;
  localparam logic [7:0] OPC_OR_IND_MASK = 8'hfe;
  localparam logic [7:0] OPC_OR_DIR      = 8'h45;
  localparam logic [7:0] OPC_OR_IMM      = 8'h44;
  localparam logic [7:0] OPC_OR_DA       = 8'h42;
  localparam logic [7:0] OPC_OR_DI       = 8'h43;

  localparam int MC_CLKS = 12;
  localparam int CYC_ONE = 1;
  localparam int CYC_TWO = 2;
  localparam int CYC_MUL = 4;
  localparam int CNT_W   = 6;

  localparam logic [CNT_W-1:0] CNT_LAST    = 6'h01;
  localparam logic [1:0]       BYTES_ONE   = 2'h1;
  localparam logic [1:0]       BYTES_TWO   = 2'h2;
  localparam logic [1:0]       BYTES_THREE = 2'h3;
  localparam logic [2:0]       WREG_HI     = 3'h0;

  typedef enum logic [3:0] {
    K_NOP, K_MUL, K_OR_RN, K_OR_DIR, K_OR_IND, K_OR_IMM, K_OR_DA, K_OR_DI, K_BAD
  } op_kind_t;

  function automatic op_kind_t decode_op(input logic [7:0] opc);
    op_kind_t k;
    k = K_BAD;
    if (opc == OPC_NOP) k = K_NOP;
    else if (opc == OPC_MUL) k = K_MUL;
    else if ((opc & OPC_OR_RN_MASK) == OPC_OR_RN) k = K_OR_RN;
    else if ((opc & OPC_OR_IND_MASK) == OPC_OR_IND) k = K_OR_IND;
    else if (opc == OPC_OR_DIR) k = K_OR_DIR;
    else if (opc == OPC_OR_IMM) k = K_OR_IMM;
    else if (opc == OPC_OR_DA) k = K_OR_DA;
    else if (opc == OPC_OR_DI) k = K_OR_DI;
    return k;
  endfunction

  // Clocks of the instruction minus one
  function automatic logic [CNT_W-1:0] op_clocks(input op_kind_t k);
    int c;
    c = CYC_ONE;
    if (k == K_MUL) c = CYC_MUL;
    else if (k == K_OR_DI) c = CYC_TWO;
    return CNT_W'(c * MC_CLKS - 1);
  endfunction

  function automatic logic [1:0] op_bytes(input op_kind_t k);
    logic [1:0] b;
    b = BYTES_ONE;
    if (k == K_OR_DIR || k == K_OR_IMM || k == K_OR_DA) b = BYTES_TWO;
    else if (k == K_OR_DI) b = BYTES_THREE;
    return b;
  endfunction

  // Working register address inside the selected bank
  function automatic logic [7:0] wreg_addr(input logic [1:0] bank, input logic [2:0] idx);
    return {WREG_HI, bank, idx};
  endfunction

endpackage

// ### byte_alu.sv
// Combinational unsigned multiplier and byte OR unit
module byte_alu (
  input  wire logic [7:0]  a_in,
  input  wire logic [7:0]  b_in,
  input  wire logic        mul_sel_in,
  output logic      [15:0] result_out
);
  always_comb begin
    if (mul_sel_in) begin
      result_out = {8'h00, a_in} * {8'h00, b_in};
    end else begin
      result_out = {8'h00, a_in | b_in};
    end
  end
endmodule

// ### mul_nop_or_byte_execute.sv
// Execute sequencer for unsigned multiply, no-operation and the byte OR family
//
// Contract
// RULE1: Multiply unsigned; low to accumulator, high to multiplier.
// RULE2: Overflow set when high byte nonzero, else cleared.
// RULE3: Multiply always clears carry.
// RULE4: No-operation: one byte, one cycle, nothing changed.
// RULE5: Byte OR stores bitwise OR, flags untouched.
// RULE6: Six source and destination combinations supported.
// RULE7: Port destination reads output latch, not pins.
// RULE8: 01001rrr: working register ORed into accumulator.
// RULE9: 01000101: direct byte ORed into accumulator.
// RULE10: 0100011i: indirect RAM byte ORed into accumulator.
// RULE11: 01000100: immediate ORed into accumulator.
// RULE12: 01000010: accumulator ORed into direct byte.
// RULE13: 01000011: immediate ORed into direct byte, two cycles.
// RULE14: Direct destination reaches any RAM or SFR.
// RULE15: Multiply and no-operation use customary encodings.
module mul_nop_or_byte_execute (
  input  wire logic       core_clk_in,
  input  wire logic       rst_in,
  input  wire logic       ce_in,
  input  wire logic       start_in,
  input  wire logic [7:0] opcode_in,
  input  wire logic [7:0] operand1_in,
  input  wire logic [7:0] operand2_in,
  input  wire logic [1:0] bank_sel_in,
  input  wire logic [7:0] acc_in,
  input  wire logic [7:0] b_in,
  input  wire logic [7:0] mem_rdata_in,
  output logic            busy_out,
  output logic            done_out,
  output logic            illegal_out,
  output logic      [1:0] pc_step_out,
  output logic            acc_wr_out,
  output logic      [7:0] acc_data_out,
  output logic            b_wr_out,
  output logic      [7:0] b_data_out,
  output logic            cy_wr_out,
  output logic            cy_data_out,
  output logic            ov_wr_out,
  output logic            ov_data_out,
  output logic            mem_rd_out,
  output logic            mem_wr_out,
  output logic      [7:0] mem_addr_out,
  output logic      [7:0] mem_wdata_out,
  output logic            mem_indirect_out,
  output logic            mem_latch_out
);
  import mul_nop_or_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_PTR, ST_OPND, ST_HOLD} state_t;

  state_t                 state;
  state_t                 next_state;
  logic                   phase;
  logic                   next_phase;
  logic       [CNT_W-1:0] cnt;
  logic       [CNT_W-1:0] next_cnt;
  op_kind_t               kind_q;
  op_kind_t               next_kind_q;
  op_kind_t               start_kind;
  logic       [7:0]       op1_q;
  logic       [7:0]       next_op1_q;
  logic       [7:0]       op2_q;
  logic       [7:0]       next_op2_q;
  logic       [7:0]       opnd_q;
  logic       [7:0]       next_opnd_q;
  logic                   next_done;
  logic                   next_illegal;
  logic       [1:0]       next_pc_step;
  logic                   next_acc_wr;
  logic       [7:0]       next_acc_data;
  logic                   next_b_wr;
  logic       [7:0]       next_b_data;
  logic                   next_cy_wr;
  logic                   next_cy_data;
  logic                   next_ov_wr;
  logic                   next_ov_data;
  logic                   next_mem_rd;
  logic                   next_mem_wr;
  logic       [7:0]       next_mem_addr;
  logic       [7:0]       next_mem_wdata;
  logic                   next_mem_indirect;
  logic                   next_mem_latch;
  logic       [7:0]       alu_a;
  logic       [7:0]       alu_b;
  logic       [15:0]      alu_res;

  assign start_kind = decode_op(opcode_in);  // [RULE15] [RULE6]
  assign busy_out   = (state != ST_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Operand selection and arithmetic

  always_comb begin
    alu_a = opnd_q;
    alu_b = acc_in;
    if (kind_q == K_MUL) begin
      alu_a = acc_in;  // [RULE1]
      alu_b = b_in;
    end else if (kind_q == K_OR_IMM) begin
      alu_a = op1_q;  // [RULE11]
    end else if (kind_q == K_OR_DI) begin
      alu_b = op2_q;  // [RULE13]
    end
  end

  byte_alu u_alu (
    .a_in       (alu_a),
    .b_in       (alu_b),
    .mul_sel_in (kind_q == K_MUL),
    .result_out (alu_res)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer and result registers

  always_comb begin
    next_state        = state;
    next_phase        = phase;
    next_cnt          = cnt;
    next_kind_q       = kind_q;
    next_op1_q        = op1_q;
    next_op2_q        = op2_q;
    next_opnd_q       = opnd_q;
    next_done         = 1'b0;
    next_illegal      = 1'b0;
    next_pc_step      = pc_step_out;
    next_acc_wr       = 1'b0;
    next_acc_data     = acc_data_out;
    next_b_wr         = 1'b0;
    next_b_data       = b_data_out;
    next_cy_wr        = 1'b0;
    next_cy_data      = cy_data_out;
    next_ov_wr        = 1'b0;
    next_ov_data      = ov_data_out;
    next_mem_rd       = 1'b0;
    next_mem_wr       = 1'b0;
    next_mem_addr     = mem_addr_out;
    next_mem_wdata    = mem_wdata_out;
    next_mem_indirect = mem_indirect_out;
    next_mem_latch    = mem_latch_out;
    if (state != ST_IDLE) begin
      next_cnt = cnt - CNT_LAST;
    end
    case (state)
      ST_IDLE: begin
        if (start_in && start_kind == K_BAD) begin
          next_illegal = 1'b1;
        end else if (start_in) begin
          next_kind_q       = start_kind;
          next_op1_q        = operand1_in;
          next_op2_q        = operand2_in;
          next_cnt          = op_clocks(start_kind);  // [RULE1] [RULE4] [RULE13]
          next_phase        = 1'b0;
          next_mem_indirect = 1'b0;
          next_mem_latch    = 1'b0;
          next_state        = ST_HOLD;
          case (start_kind)
            K_OR_RN: begin
              next_state    = ST_OPND;
              next_mem_rd   = 1'b1;
              next_mem_addr = wreg_addr(bank_sel_in, opcode_in[2:0]);  // [RULE8]
            end
            K_OR_IND: begin
              next_state    = ST_PTR;
              next_mem_rd   = 1'b1;
              next_mem_addr = wreg_addr(bank_sel_in, {2'h0, opcode_in[0]});  // [RULE10]
            end
            K_OR_DIR: begin
              next_state    = ST_OPND;
              next_mem_rd   = 1'b1;
              next_mem_addr = operand1_in;  // [RULE9]
            end
            K_OR_DA, K_OR_DI: begin
              next_state     = ST_OPND;
              next_mem_rd    = 1'b1;
              next_mem_addr  = operand1_in;  // [RULE12] [RULE14]
              next_mem_latch = 1'b1;  // [RULE7]
            end
            default: begin
              next_state = ST_HOLD;
            end
          endcase
        end
      end
      ST_PTR: begin
        next_phase = ~phase;
        if (phase) begin
          next_state        = ST_OPND;
          next_mem_rd       = 1'b1;
          next_mem_addr     = mem_rdata_in;  // [RULE10]
          next_mem_indirect = 1'b1;
        end
      end
      ST_OPND: begin
        next_phase = ~phase;
        if (phase) begin
          next_opnd_q = mem_rdata_in;
          next_state  = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (cnt == CNT_LAST) begin
          next_state   = ST_IDLE;
          next_done    = 1'b1;
          next_pc_step = op_bytes(kind_q);  // [RULE4]
          case (kind_q)
            K_MUL: begin
              next_acc_wr   = 1'b1;
              next_acc_data = alu_res[7:0];  // [RULE1]
              next_b_wr     = 1'b1;
              next_b_data   = alu_res[15:8];  // [RULE1]
              next_ov_wr    = 1'b1;
              next_ov_data  = |alu_res[15:8];  // [RULE2]
              next_cy_wr    = 1'b1;
              next_cy_data  = 1'b0;  // [RULE3]
            end
            K_OR_RN, K_OR_DIR, K_OR_IND, K_OR_IMM: begin
              next_acc_wr   = 1'b1;
              next_acc_data = alu_res[7:0];  // [RULE5] [RULE6]
            end
            K_OR_DA, K_OR_DI: begin
              next_mem_wr       = 1'b1;
              next_mem_addr     = op1_q;  // [RULE14]
              next_mem_wdata    = alu_res[7:0];  // [RULE5] [RULE12] [RULE13]
              next_mem_indirect = 1'b0;
              next_mem_latch    = 1'b0;
            end
            default: begin
              next_acc_wr = 1'b0;  // [RULE4]
            end
          endcase
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state            <= ST_IDLE;
      phase            <= 1'b0;
      cnt              <= '0;
      kind_q           <= K_NOP;
      op1_q            <= 8'h00;
      op2_q            <= 8'h00;
      opnd_q           <= 8'h00;
      done_out         <= 1'b0;
      illegal_out      <= 1'b0;
      pc_step_out      <= 2'h0;
      acc_wr_out       <= 1'b0;
      acc_data_out     <= 8'h00;
      b_wr_out         <= 1'b0;
      b_data_out       <= 8'h00;
      cy_wr_out        <= 1'b0;
      cy_data_out      <= 1'b0;
      ov_wr_out        <= 1'b0;
      ov_data_out      <= 1'b0;
      mem_rd_out       <= 1'b0;
      mem_wr_out       <= 1'b0;
      mem_addr_out     <= 8'h00;
      mem_wdata_out    <= 8'h00;
      mem_indirect_out <= 1'b0;
      mem_latch_out    <= 1'b0;
    end else if (ce_in) begin
      state            <= next_state;
      phase            <= next_phase;
      cnt              <= next_cnt;
      kind_q           <= next_kind_q;
      op1_q            <= next_op1_q;
      op2_q            <= next_op2_q;
      opnd_q           <= next_opnd_q;
      done_out         <= next_done;
      illegal_out      <= next_illegal;
      pc_step_out      <= next_pc_step;
      acc_wr_out       <= next_acc_wr;
      acc_data_out     <= next_acc_data;
      b_wr_out         <= next_b_wr;
      b_data_out       <= next_b_data;
      cy_wr_out        <= next_cy_wr;
      cy_data_out      <= next_cy_data;
      ov_wr_out        <= next_ov_wr;
      ov_data_out      <= next_ov_data;
      mem_rd_out       <= next_mem_rd;
      mem_wr_out       <= next_mem_wr;
      mem_addr_out     <= next_mem_addr;
      mem_wdata_out    <= next_mem_wdata;
      mem_indirect_out <= next_mem_indirect;
      mem_latch_out    <= next_mem_latch;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  // Edges from the take to the sample of the done clock
  localparam int MUL_LAST = CYC_MUL * MC_CLKS;
  localparam int ONE_LAST = CYC_ONE * MC_CLKS;
  localparam int TWO_LAST = CYC_TWO * MC_CLKS;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in || !ce_in);

  sequence seq_take(op_kind_t k);
    start_in && !busy_out && start_kind == k;
  endsequence

  sequence seq_commit(op_kind_t k);
    done_out && kind_q == k;
  endsequence

  AST_MUL_PRODUCT: assert property (seq_commit(K_MUL) |-> acc_wr_out && b_wr_out && // [RULE1]
      {b_data_out, acc_data_out} == $past(acc_in) * $past(b_in))
    else $error("Multiply result wrong");
  AST_MUL_TIME: assert property (seq_take(K_MUL) |-> ##MUL_LAST (done_out && pc_step_out == BYTES_ONE)) // [RULE1]
    else $error("Multiply length wrong");
  AST_MUL_OV: assert property (seq_commit(K_MUL) |-> ov_wr_out && ov_data_out == (b_data_out != 8'h00)) // [RULE2]
    else $error("Overflow flag wrong after multiply");
  AST_MUL_CY: assert property (seq_commit(K_MUL) |-> cy_wr_out && !cy_data_out) // [RULE3]
    else $error("Carry not cleared by multiply");
  AST_NOP_QUIET: assert property (seq_take(K_NOP) |-> ##ONE_LAST (done_out && pc_step_out == BYTES_ONE && // [RULE4]
      !acc_wr_out && !b_wr_out && !mem_wr_out && !cy_wr_out && !ov_wr_out))
    else $error("No-operation altered state or took wrong time");
  AST_OR_FLAGS: assert property (done_out && kind_q != K_MUL |-> !cy_wr_out && !ov_wr_out) // [RULE5]
    else $error("Byte OR touched flags");
  AST_OR_IMM: assert property (seq_commit(K_OR_IMM) |-> acc_wr_out && // [RULE11]
      acc_data_out == ($past(acc_in) | op1_q))
    else $error("Immediate OR into accumulator wrong");
  AST_RMW_LATCH: assert property ((seq_take(K_OR_DA) or seq_take(K_OR_DI)) |=> // [RULE7]
      mem_rd_out && mem_latch_out && mem_addr_out == $past(operand1_in))
    else $error("Read of direct destination not from latch");
  AST_RN_ADDR: assert property (seq_take(K_OR_RN) |=> // [RULE8]
      mem_rd_out && mem_addr_out == wreg_addr($past(bank_sel_in), $past(opcode_in[2:0])))
    else $error("Working register address wrong");
  AST_DI_TIME: assert property (seq_take(K_OR_DI) |-> ##TWO_LAST (done_out && mem_wr_out && // [RULE13]
      pc_step_out == BYTES_THREE && mem_wdata_out == (opnd_q | op2_q)))
    else $error("Immediate OR into direct byte wrong");
  AST_DA_WRITE: assert property (seq_take(K_OR_DA) |-> ##ONE_LAST (done_out && mem_wr_out && // [RULE12]
      pc_step_out == BYTES_TWO && mem_wdata_out == (opnd_q | $past(acc_in))))
    else $error("Accumulator OR into direct byte wrong");

endmodule

// ### mem_model.sv
// Memory model: internal RAM, upper indirect RAM, port latches and port pins
module mem_model (
  input  wire logic       clk_in,
  input  wire logic       rd_in,
  input  wire logic       wr_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       ind_in,
  input  wire logic       latch_in,
  output logic      [7:0] rdata_out
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] ram [0:255];
  logic [7:0] hi  [0:127];

  initial rdata_out = 8'h5a;

  ////////////////////////////////////////////////////////////////////////////
  // One cycle read latency, stale data toggles
  always @(posedge clk_in) begin
    if (rd_in) begin
      if (ind_in && addr_in[7]) begin
        rdata_out <= hi[addr_in[6:0]];
      end else if (!ind_in && !latch_in && addr_in[7:6] == 2'h2 && addr_in[3:0] == 4'h0) begin
        rdata_out <= ~ram[addr_in]; // Pins differ from the output latch
      end else begin
        rdata_out <= ram[addr_in]; // Latch or RAM byte
      end
    end else begin
      rdata_out <= ~rdata_out;
    end
    if (wr_in) begin
      ram[addr_in] <= wdata_in; // Any RAM or SFR byte
    end
  end
endmodule

// ### tb.sv
// Self-checking testbench for the multiply, no-operation and byte OR unit
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mul_nop_or_pkg::*;

  logic       core_clk_in, rst_in, ce_in, start_in, busy_out, done_out, illegal_out;
  logic       acc_wr_out, b_wr_out, cy_wr_out, cy_data_out, ov_wr_out, ov_data_out;
  logic       mem_rd_out, mem_wr_out, mem_indirect_out, mem_latch_out;
  logic [1:0] bank_sel_in, pc_step_out;
  logic [7:0] opcode_in, operand1_in, operand2_in, acc_in, b_in, mem_rdata_in;
  logic [7:0] acc_data_out, b_data_out, mem_addr_out, mem_wdata_out, nacc, nb, op;
  logic [7:0] ram [0:255];
  logic [7:0] hi  [0:127];
  logic [7:0] op_q [$];
  logic [7:0] o1_q [$];
  logic [7:0] o2_q [$];
  logic [1:0] bk_q [$];
  int         err_count, checks_done, seed, i;
  int         cycles = 0;

  mul_nop_or_byte_execute mul_nop_or_byte_execute_inst (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .ce_in(ce_in), .start_in(start_in), .opcode_in(opcode_in),
    .operand1_in(operand1_in), .operand2_in(operand2_in), .bank_sel_in(bank_sel_in), .acc_in(acc_in),
    .b_in(b_in), .mem_rdata_in(mem_rdata_in), .busy_out(busy_out), .done_out(done_out),
    .illegal_out(illegal_out), .pc_step_out(pc_step_out), .acc_wr_out(acc_wr_out), .acc_data_out(acc_data_out),
    .b_wr_out(b_wr_out), .b_data_out(b_data_out), .cy_wr_out(cy_wr_out), .cy_data_out(cy_data_out),
    .ov_wr_out(ov_wr_out), .ov_data_out(ov_data_out), .mem_rd_out(mem_rd_out), .mem_wr_out(mem_wr_out),
    .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out), .mem_indirect_out(mem_indirect_out),
    .mem_latch_out(mem_latch_out));

  mem_model mem_model_inst (
    .clk_in(core_clk_in), .rd_in(mem_rd_out), .wr_in(mem_wr_out), .addr_in(mem_addr_out),
    .wdata_in(mem_wdata_out), .ind_in(mem_indirect_out), .latch_in(mem_latch_out), .rdata_out(mem_rdata_in));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk_in = 1'b0;
    forever #10 core_clk_in = ~core_clk_in;
  end

  always @(posedge core_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Non-latch read as seen by the core: port addresses return the pins
  function automatic logic [7:0] rd(input logic [7:0] a, input logic ind);
    if (ind && a[7]) return hi[a[6:0]];
    if (!ind && a[7:6] == 2'h2 && a[3:0] == 4'h0) return ~ram[a];
    return ram[a];
  endfunction

  task automatic present(input int k);
    start_in    <= (k < op_q.size());
    opcode_in   <= (k < op_q.size()) ? op_q[k] : 8'h00;
    operand1_in <= (k < op_q.size()) ? o1_q[k] : 8'h00;
    operand2_in <= (k < op_q.size()) ? o2_q[k] : 8'h00;
    bank_sel_in <= (k < op_q.size()) ? bk_q[k] : 2'h0;
  endtask

  task automatic push(input logic [7:0] o, input logic [7:0] a1);
    op_q.push_back(o);
    o1_q.push_back(a1);
    o2_q.push_back(8'($random(seed)));
    bk_q.push_back(2'($random(seed)));
  endtask

  // Runs the op already on the inputs; the next op is presented at the take edge
  task automatic run(input int k);
    logic [7:0]  o, o1, src, ea, eb, ed;
    logic [15:0] prod;
    logic [4:0]  ew;
    logic [1:0]  bk, by;
    int          cyc, n;
    if (k > 0 && op_q[k] == OPC_MUL) nb = 8'($random(seed)) & 8'h03; // Other code may reload B between multiplies
    o = op_q[k]; o1 = o1_q[k]; bk = bk_q[k]; cyc = 1; by = 2'h1; ew = 5'h0; ea = nacc; eb = nb; ed = 8'h00;
    @(posedge core_clk_in);
    acc_in <= nacc;
    b_in <= nb;
    present(k + 1);
    casez (o)
      8'h00: ew = 5'h0;
      8'ha4: begin cyc = 4; ew = 5'b11110; prod = nacc * nb; ea = prod[7:0]; eb = prod[15:8]; end
      8'b01001???: begin ew = 5'b10000; src = ram[{3'h0, bk, o[2:0]}]; end
      8'h46, 8'h47: begin ew = 5'b10000; src = rd(ram[{3'h0, bk, 2'h0, o[0]}], 1'b1); end
      8'h45: begin by = 2'h2; ew = 5'b10000; src = rd(o1, 1'b0); end
      8'h44: begin by = 2'h2; ew = 5'b10000; src = o1; end
      8'h42: begin by = 2'h2; ew = 5'b00001; ed = ram[o1] | nacc; end
      8'h43: begin by = 2'h3; cyc = 2; ew = 5'b00001; ed = ram[o1] | o2_q[k]; end
      default: cyc = 0;
    endcase
    if (ew == 5'b10000) ea = nacc | src;
    @(negedge core_clk_in);
    if (cyc == 0) begin
      chk("illegal", 2'b10, {illegal_out, busy_out});
      return;
    end
    chk("busy at start", 1, busy_out);
    n = 0;
    while (done_out !== 1'b1 && n < 60) begin
      @(negedge core_clk_in);
      n++;
    end
    chk("cycles", cyc * MC_CLKS - 1, n);
    chk("pc step", by, pc_step_out);
    chk("strobes", ew, {acc_wr_out, b_wr_out, cy_wr_out, ov_wr_out, mem_wr_out});
    if (ew[4]) chk("acc data", ea, acc_data_out);
    if (ew[3]) chk("b data", eb, b_data_out);
    if (ew[2]) chk("carry", 0, cy_data_out);
    if (ew[1]) chk("overflow", |eb, ov_data_out);
    if (ew[0]) chk("mem write", {o1, ed}, {mem_addr_out, mem_wdata_out});
    if (ew[0]) ram[o1] = ed;
    nacc = ea;
    nb = eb;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h6908;
    err_count = 0;
    checks_done = 0;
    rst_in = 1'b1; ce_in = 1'b1; start_in = 1'b0; opcode_in = 8'h00; operand1_in = 8'h00;
    operand2_in = 8'h00; bank_sel_in = 2'h0; acc_in = 8'h50; b_in = 8'ha0; nacc = 8'h50; nb = 8'ha0;
    for (i = 0; i < 256; i++) begin
      ram[i] = 8'($random(seed));
      mem_model_inst.ram[i] = ram[i];
      if (i < 128) hi[i] = 8'($random(seed));
      if (i < 128) mem_model_inst.hi[i] = hi[i];
    end
    push(8'ha4, 8'h00);
    push(8'h00, 8'h00);
    for (i = 0; i < 8; i++) push(8'h48 + 8'(i), 8'h00);
    push(8'h45, 8'h90); push(8'h46, 8'h00); push(8'h47, 8'h00); push(8'h44, 8'h3c);
    push(8'h42, 8'ha0); push(8'h43, 8'h80); push(8'h50, 8'h00); push(8'ha4, 8'h00);
    for (i = 0; i < 60; i++) begin
      op = 8'h40 + 8'($unsigned($random(seed)) % 16);
      if (i % 7 == 0) op = 8'ha4;
      if (i % 11 == 0) op = 8'h00;
      push(op, ($random(seed) & 3) == 0 ? {2'h2, 2'($random(seed)), 4'h0} : 8'($random(seed)));
    end
    repeat (20) @(posedge core_clk_in);
    @(negedge core_clk_in);
    chk("reset outputs", 0, {done_out, busy_out, acc_wr_out, mem_wr_out, pc_step_out});
    @(posedge core_clk_in);
    rst_in <= 1'b0;
    present(0);
    for (i = 0; i < 17; i++) run(i);
    $display("directed sweep done");
    for (i = 17; i < op_q.size(); i++) run(i);
    $display("random back-to-back run done");
    report_and_stop();
  end
endmodule
